// [asi_pkg.sv]
/*
 * Constants and carrier types for the A/D and system instruction group
 * of a 4-bit core. Assumes a single clock domain and a 32-bit AXI4-Lite
 * register bus on the same clock.
 */
`default_nettype none
package asi_pkg;
	localparam int INSN_W = 10;
	localparam int HI_W   = 6;
	localparam int LO_W   = 4;
	typedef struct packed {
		logic [HI_W-1:0] hi;
		logic [LO_W-1:0] lo;
	} asi_insn_t;
	localparam logic [9:0] OP_LOAD_AB_FROM_CONVERSION      = 10'h279;
	localparam logic [9:0] OP_LOAD_ACC_FROM_RESULT_LOW     = 10'h249;
	localparam logic [9:0] OP_STORE_AB_TO_COMPARATOR       = 10'h239;
	localparam logic [9:0] OP_LOAD_ACC_FROM_CONVERTER_CTRL = 10'h244;
	localparam logic [9:0] OP_STORE_ACC_TO_CONVERTER_CTRL  = 10'h204;
	localparam logic [9:0] OP_CONVERSION_START             = 10'h29F;
	localparam logic [9:0] OP_SKIP_IF_CONVERSION_DONE      = 10'h287;
	localparam logic [9:0] OP_NO_OPERATION                 = 10'h000;
	localparam logic [9:0] OP_RAM_BACKUP_ENTER             = 10'h008;
	localparam logic [9:0] OP_POWERDOWN_ARM                = 10'h05B;
	localparam logic [9:0] OP_SKIP_IF_POWERDOWN_FLAG       = 10'h003;
	localparam logic [9:0] OP_WATCHDOG_DISABLE_ARM         = 10'h29C;
	localparam logic [9:0] OP_WATCHDOG_RESTART             = 10'h2A0;
	localparam logic [9:0] OP_SELECT_CERAMIC_OSC           = 10'h29A;
	localparam logic [9:0] OP_SELECT_RC_OSC                = 10'h29B;
	localparam logic [9:0] OP_LOAD_ACC_FROM_CLOCK_CTRL     = 10'h252;
	localparam logic [9:0] OP_STORE_ACC_TO_CLOCK_CTRL      = 10'h216;
	// Field positions
	localparam int COMPARATOR_MODE_BIT = 3;
	localparam int IRQ_SELECT_BIT      = 2;
	// Register map, byte addresses
	localparam logic [7:0] ADDR_CONTROL    = 8'h00;
	localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_STATUS     = 8'h08;
	localparam logic [7:0] ADDR_COMPARATOR = 8'h0C;
	localparam logic [7:0] ADDR_RESULT     = 8'h10;
	localparam int CTRL_CONV_LSB  = 0;
	localparam int CTRL_CLOCK_LSB = 4;
	localparam int ST_DONE   = 0;
	localparam int ST_WATCHDOG_FLAG_ONE   = 1;
	localparam int ST_PDF    = 2;
	localparam int ST_BACKUP = 3;
	localparam int ST_WDT_OFF = 4;
	localparam int ST_OSC_LSB = 5;
	// Reset values
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ASI_OSC_ONCHIP,
		ASI_OSC_CERAMIC,
		ASI_OSC_RC
	} asi_osc_t;
	// Write-back to the core registers, one pulse per instruction
	typedef struct packed {
		logic       acc_we;
		logic [3:0] acc;
		logic       b_we;
		logic [3:0] b;
		logic       skip;
		logic       pc_inc;
	} asi_wb_t;
endpackage
`default_nettype wire

// [asi_core.sv]
/*
 * Execution unit for the A/D and system instruction group, plus an
 * AXI4-Lite slave for the converter, clock and interrupt-select state.
 * Assumes the core presents one decoded word per INSN_VALID pulse with its
 * A and B registers, and that converter and watchdog pulse their flag sets.
 */
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module asi_core #(
	parameter int RESULT_W = 10
) (
	// Clock, reset, enable
	input  wire logic                  SYS_CLK,
	input  wire logic                  ARST_N,
	input  wire logic                  CE,
	// Instruction from the core
	input  wire logic                  INSN_VALID,
	input  wire asi_pkg::asi_insn_t    INSN,
	input  wire logic [3:0]            ACC_IN,
	input  wire logic [3:0]            B_IN,
	output asi_pkg::asi_wb_t           WB,
	// Converter, watchdog, power-down
	input  wire logic [RESULT_W-1:0]   ADC_RESULT,
	input  wire logic                  CONV_DONE_SET,
	input  wire logic                  WATCHDOG_FLAG_ONE_SET,
	input  wire logic                  PD_FLAG,
	output logic                       CONV_START,
	output logic                       CMP_START,
	output logic                       BACKUP,
	output logic                       WDT_STOP,
	output logic [1:0]                 OSC_SEL,
	output logic                       ONCHIP_OSC_STOP,
	// AXI4-Lite slave
	input  wire logic [7:0]            AWADDR,
	input  wire logic                  AWVALID,
	output logic                       AWREADY,
	input  wire logic [31:0]           WDATA,
	input  wire logic [3:0]            WSTRB,
	input  wire logic                  WVALID,
	output logic                       WREADY,
	output logic [1:0]                 BRESP,
	output logic                       BVALID,
	input  wire logic                  BREADY,
	input  wire logic [7:0]            ARADDR,
	input  wire logic                  ARVALID,
	output logic                       ARREADY,
	output logic [31:0]                RDATA,
	output logic [1:0]                 RRESP,
	output logic                       RVALID,
	input  wire logic                  RREADY
);
	typedef enum logic {
		ASI_WR_COLLECT,
		ASI_WR_RESP
	} asi_wr_t;

	logic [3:0]  converter_control_reg;
	logic [3:0]  clock_control_reg;
	logic [3:0]  interrupt_control_two;
	logic [7:0]  comparator_reg;
	logic        conversion_done_flag;
	logic        watchdog_flag_one;
	logic        backup_armed;
	logic        wdt_disable_armed;
	asi_pkg::asi_osc_t osc;
	asi_wr_t     wr_state;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	logic [9:0]  op;
	logic        exec;
	logic        comparator_mode;
	logic        converter_irq_select_bit;
	logic        done_clr;
	logic        watchdog_flag_one_clr;
	logic        bus_wr;
	logic        next_done;
	logic        next_watchdog_flag_one;
	asi_pkg::asi_wb_t next_wb;

	// Backup freezes instruction execution; the bus stays live for debug
	assign op = INSN;
	assign exec = CE && INSN_VALID && !BACKUP;
	assign comparator_mode = converter_control_reg[asi_pkg::COMPARATOR_MODE_BIT];
	assign converter_irq_select_bit = interrupt_control_two[asi_pkg::IRQ_SELECT_BIT];
	assign ONCHIP_OSC_STOP = (osc != asi_pkg::ASI_OSC_ONCHIP);
	assign OSC_SEL = osc;

	// Decode: write-back to A and B, skip, and the flag clears
	always_comb begin
		next_wb = '0;
		next_wb.pc_inc = exec;
		done_clr = 1'b0;
		watchdog_flag_one_clr = 1'b0;
		if (exec) begin
			case (op)
				asi_pkg::OP_LOAD_AB_FROM_CONVERSION: begin
					next_wb.acc_we = 1'b1;
					next_wb.b_we = 1'b1;
					if (comparator_mode) begin
						next_wb.b = comparator_reg[7:4];
						next_wb.acc = comparator_reg[3:0];
					end else begin
						next_wb.b = ADC_RESULT[9:6];
						next_wb.acc = ADC_RESULT[5:2];
					end
				end
				asi_pkg::OP_LOAD_ACC_FROM_RESULT_LOW: begin
					next_wb.acc_we = 1'b1;
					next_wb.acc = {ADC_RESULT[1:0], 2'h0};
				end
				asi_pkg::OP_LOAD_ACC_FROM_CONVERTER_CTRL: begin
					next_wb.acc_we = 1'b1;
					next_wb.acc = converter_control_reg;
				end
				asi_pkg::OP_LOAD_ACC_FROM_CLOCK_CTRL: begin
					next_wb.acc_we = 1'b1;
					next_wb.acc = clock_control_reg;
				end
				asi_pkg::OP_CONVERSION_START: begin
					done_clr = 1'b1;
				end
				asi_pkg::OP_SKIP_IF_CONVERSION_DONE: begin
					if (!converter_irq_select_bit && conversion_done_flag) begin
						next_wb.skip = 1'b1;
						done_clr = 1'b1;
					end
				end
				asi_pkg::OP_SKIP_IF_POWERDOWN_FLAG: begin
					next_wb.skip = PD_FLAG;
				end
				asi_pkg::OP_WATCHDOG_RESTART: begin
					if (watchdog_flag_one) begin
						next_wb.skip = 1'b1;
						watchdog_flag_one_clr = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// A set arriving with a clear wins, so no completion is lost
	assign next_done = CONV_DONE_SET || (conversion_done_flag && !done_clr);
	assign next_watchdog_flag_one = WATCHDOG_FLAG_ONE_SET || (watchdog_flag_one && !watchdog_flag_one_clr);

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB <= '0;
		end else if (CE) begin
			WB <= next_wb;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			conversion_done_flag <= 1'b0;
			watchdog_flag_one <= 1'b0;
		end else if (CE) begin
			conversion_done_flag <= next_done;
			watchdog_flag_one <= next_watchdog_flag_one;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CONV_START <= 1'b0;
			CMP_START <= 1'b0;
		end else if (CE) begin
			CONV_START <= exec && op == asi_pkg::OP_CONVERSION_START && !comparator_mode;
			CMP_START <= exec && op == asi_pkg::OP_CONVERSION_START && comparator_mode;
		end
	end

	// Arming lasts exactly one instruction, whatever that instruction is
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			backup_armed <= 1'b0;
			wdt_disable_armed <= 1'b0;
			BACKUP <= 1'b0;
			WDT_STOP <= 1'b0;
		end else if (CE && exec) begin
			backup_armed <= (op == asi_pkg::OP_POWERDOWN_ARM);
			wdt_disable_armed <= (op == asi_pkg::OP_WATCHDOG_DISABLE_ARM);
			if (op == asi_pkg::OP_RAM_BACKUP_ENTER && backup_armed) begin
				BACKUP <= 1'b1;
			end
			if (op == asi_pkg::OP_WATCHDOG_RESTART && wdt_disable_armed) begin
				WDT_STOP <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			osc <= asi_pkg::ASI_OSC_ONCHIP;
		end else if (CE && exec) begin
			if (op == asi_pkg::OP_SELECT_CERAMIC_OSC) begin
				osc <= asi_pkg::ASI_OSC_CERAMIC;
			end else if (op == asi_pkg::OP_SELECT_RC_OSC) begin
				osc <= asi_pkg::ASI_OSC_RC;
			end
		end
	end

	// Software registers; an instruction in the same cycle takes precedence
	assign bus_wr = CE && wr_state == ASI_WR_COLLECT && aw_held && w_held;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			converter_control_reg <= asi_pkg::RST_NIBBLE;
			clock_control_reg <= asi_pkg::RST_NIBBLE;
			interrupt_control_two <= asi_pkg::RST_NIBBLE;
			comparator_reg <= asi_pkg::RST_BYTE;
		end else if (CE) begin
			if (bus_wr && w_strb[0]) begin
				case (aw_addr)
					asi_pkg::ADDR_CONTROL: begin
						converter_control_reg <= w_data[asi_pkg::CTRL_CONV_LSB +: 4];
						clock_control_reg <= w_data[asi_pkg::CTRL_CLOCK_LSB +: 4];
					end
					asi_pkg::ADDR_IRQ_CTRL: begin
						interrupt_control_two <= w_data[3:0];
					end
					asi_pkg::ADDR_COMPARATOR: begin
						comparator_reg <= w_data[7:0];
					end
					default: begin
					end
				endcase
			end
			if (exec) begin
				case (op)
					asi_pkg::OP_STORE_ACC_TO_CONVERTER_CTRL: begin
						converter_control_reg <= ACC_IN;
					end
					asi_pkg::OP_STORE_ACC_TO_CLOCK_CTRL: begin
						clock_control_reg <= ACC_IN;
					end
					asi_pkg::OP_STORE_AB_TO_COMPARATOR: begin
						if (comparator_mode) begin
							comparator_reg <= {B_IN, ACC_IN};
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Write channel: address and data may come in either order
	assign AWREADY = CE && wr_state == ASI_WR_COLLECT && !aw_held;
	assign WREADY = CE && wr_state == ASI_WR_COLLECT && !w_held;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_state <= ASI_WR_COLLECT;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= asi_pkg::RST_BYTE;
			w_data <= '0;
			w_strb <= asi_pkg::RST_NIBBLE;
			BVALID <= 1'b0;
			BRESP <= asi_pkg::RESP_OKAY;
		end else if (CE) begin
			case (wr_state)
				ASI_WR_COLLECT: begin
					if (AWVALID && AWREADY) begin
						aw_held <= 1'b1;
						aw_addr <= AWADDR;
					end
					if (WVALID && WREADY) begin
						w_held <= 1'b1;
						w_data <= WDATA;
						w_strb <= WSTRB;
					end
					if (bus_wr) begin
						aw_held <= 1'b0;
						w_held <= 1'b0;
						BVALID <= 1'b1;
						BRESP <= (aw_addr == asi_pkg::ADDR_CONTROL
							|| aw_addr == asi_pkg::ADDR_IRQ_CTRL
							|| aw_addr == asi_pkg::ADDR_COMPARATOR)
							? asi_pkg::RESP_OKAY : asi_pkg::RESP_SLVERR;
						wr_state <= ASI_WR_RESP;
					end
				end
				ASI_WR_RESP: begin
					if (BREADY) begin
						BVALID <= 1'b0;
						wr_state <= ASI_WR_COLLECT;
					end
				end
				default: begin
					wr_state <= ASI_WR_COLLECT;
				end
			endcase
		end
	end

	// Read channel: one read at a time, data registered
	assign ARREADY = CE && !RVALID;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= asi_pkg::RESP_OKAY;
		end else if (CE) begin
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA <= '0;
				RRESP <= asi_pkg::RESP_OKAY;
				case (ARADDR)
					asi_pkg::ADDR_CONTROL: begin
						RDATA[asi_pkg::CTRL_CONV_LSB +: 4] <= converter_control_reg;
						RDATA[asi_pkg::CTRL_CLOCK_LSB +: 4] <= clock_control_reg;
					end
					asi_pkg::ADDR_IRQ_CTRL: begin
						RDATA[3:0] <= interrupt_control_two;
					end
					asi_pkg::ADDR_STATUS: begin
						RDATA[asi_pkg::ST_DONE] <= conversion_done_flag;
						RDATA[asi_pkg::ST_WATCHDOG_FLAG_ONE] <= watchdog_flag_one;
						RDATA[asi_pkg::ST_PDF] <= PD_FLAG;
						RDATA[asi_pkg::ST_BACKUP] <= BACKUP;
						RDATA[asi_pkg::ST_WDT_OFF] <= WDT_STOP;
						RDATA[asi_pkg::ST_OSC_LSB +: 2] <= osc;
					end
					asi_pkg::ADDR_COMPARATOR: begin
						RDATA[7:0] <= comparator_reg;
					end
					asi_pkg::ADDR_RESULT: begin
						RDATA[RESULT_W-1:0] <= ADC_RESULT;
					end
					default: begin
						RRESP <= asi_pkg::RESP_SLVERR;
					end
				endcase
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule // asi_core
`default_nettype wire

// [asi_core_props.sv]
/* Assertions on the asi_core instruction side.
   Assumes one clock domain; bound to every asi_core below. */
`timescale 1ns/1ps
`default_nettype none
module asi_core_props #(
	parameter int RESULT_W = 10
) (
	// Clock and instruction side
	input wire logic                SYS_CLK,
	input wire logic                ARST_N,
	input wire logic                CE,
	input wire logic                INSN_VALID,
	input wire asi_pkg::asi_insn_t  INSN,
	input wire asi_pkg::asi_wb_t    WB,
	// Converter and system side
	input wire logic [RESULT_W-1:0] ADC_RESULT,
	input wire logic                PD_FLAG,
	input wire logic                CONV_START,
	input wire logic                CMP_START,
	input wire logic                BACKUP,
	input wire logic                WDT_STOP,
	input wire logic [1:0]          OSC_SEL,
	input wire logic                ONCHIP_OSC_STOP
);
	logic       tk;
	logic [1:0] res_lo;
	assign tk = CE && INSN_VALID && !BACKUP;
	// Result bits as seen at the executing edge
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			res_lo <= 2'h0;
		else
			res_lo <= ADC_RESULT[1:0];
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	chk_pc_step: assert property (tk |=> WB.pc_inc)
		else $error("executed word gave no pc step");
	chk_frozen_core: assert property (BACKUP |=> BACKUP && !WB.pc_inc)
		else $error("back-up state left or word executed");
	chk_low_xfer: assert property (tk
		&& INSN == asi_pkg::OP_LOAD_ACC_FROM_RESULT_LOW
		|=> WB.acc_we && WB.acc == {res_lo, 2'h0})
		else $error("low result transfer wrong");
	chk_start_one: assert property (tk && INSN == asi_pkg::OP_CONVERSION_START
		|=> CONV_START ^ CMP_START)
		else $error("start gave no single start pulse");
	chk_pd_skip: assert property (tk && INSN == asi_pkg::OP_SKIP_IF_POWERDOWN_FLAG
		|=> WB.skip == $past(PD_FLAG))
		else $error("power-down skip wrong");
	chk_backup_arm: assert property ((tk && INSN == asi_pkg::OP_POWERDOWN_ARM) ##1
		(tk && INSN == asi_pkg::OP_RAM_BACKUP_ENTER) |=> BACKUP)
		else $error("armed back-up entry ignored");
	chk_backup_why: assert property ($rose(BACKUP)
		|-> $past(tk) && $past(INSN) == asi_pkg::OP_RAM_BACKUP_ENTER)
		else $error("back-up entered without entry word");
	chk_wdt_arm: assert property ((tk
		&& INSN == asi_pkg::OP_WATCHDOG_DISABLE_ARM) ##1
		(tk && INSN == asi_pkg::OP_WATCHDOG_RESTART) |=> WDT_STOP)
		else $error("watchdog not stopped");
	chk_ceramic_sel: assert property (tk && INSN == asi_pkg::OP_SELECT_CERAMIC_OSC
		|=> OSC_SEL == 2'h1 && ONCHIP_OSC_STOP)
		else $error("ceramic select wrong");
	chk_rc_sel: assert property (tk && INSN == asi_pkg::OP_SELECT_RC_OSC
		|=> OSC_SEL == 2'h2 && ONCHIP_OSC_STOP)
		else $error("rc select wrong");
endmodule // asi_core_props
bind asi_core asi_core_props #(.RESULT_W(RESULT_W)) u_asi_core_props (
	.SYS_CLK, .ARST_N, .CE, .INSN_VALID, .INSN, .WB, .ADC_RESULT, .PD_FLAG,
	.CONV_START, .CMP_START, .BACKUP, .WDT_STOP, .OSC_SEL, .ONCHIP_OSC_STOP
);
`default_nettype wire

// [test_adc_and_system_instructions.sv]
/* Self-checking bench for asi_core: instruction group and registers.
   Assumes asi_pkg and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_adc_and_system_instructions;
	logic               clk, rst_n, iv, dset, wset, pd;
	logic               ce, cs, ms, cm;
	logic               awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic [1:0]         bresp, rresp;
	logic [3:0]         acc, bb, a, b;
	logic [7:0]         awa, ara;
	logic [9:0]         res;
	logic [31:0]        wd, rdat, seed, r;
	logic [65:0]        re;
	asi_pkg::asi_insn_t insn;
	asi_pkg::asi_wb_t   wb;
	asi_pkg::asi_wb_t   wq[$];
	logic [65:0]        rq[$];
	logic [1:0]         sq[$];
	int                 num_errors, checks_done;

	asi_core u_asi_core (
		.SYS_CLK(clk), .ARST_N(rst_n), .CE(ce), .INSN_VALID(iv), .INSN(insn),
		.ACC_IN(acc), .B_IN(bb), .WB(wb), .ADC_RESULT(res), .CONV_DONE_SET(dset),
		.WATCHDOG_FLAG_ONE_SET(wset), .PD_FLAG(pd), .CONV_START(cs), .CMP_START(ms), .BACKUP(),
		.WDT_STOP(), .OSC_SEL(), .ONCHIP_OSC_STOP(), .AWADDR(awa), .AWVALID(awv),
		.AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wrd),
		.BRESP(bresp), .BVALID(bv), .BREADY(br), .ARADDR(ara), .ARVALID(arv),
		.ARREADY(arr), .RDATA(rdat), .RRESP(rresp), .RVALID(rv), .RREADY(rr)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Unwritten nibbles are don't-care, so both sides are masked alike
	function automatic asi_pkg::asi_wb_t ew(input logic aw, input logic [3:0] x,
		input logic bw, input logic [3:0] y, input logic sk);
		ew = '{aw, aw ? x : 4'h0, bw, bw ? y : 4'h0, sk, 1'b1};
	endfunction

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic ex(input logic [9:0] w, input logic [3:0] x, input logic [3:0] y,
		input asi_pkg::asi_wb_t e);
		@(posedge clk);
		iv <= 1'b1;
		insn <= w;
		acc <= x;
		bb <= y;
		if (e.pc_inc) begin
			wq.push_back(e);
			sq.push_back({w == asi_pkg::OP_CONVERSION_START && !cm,
				w == asi_pkg::OP_CONVERSION_START && cm});
		end
	endtask

	task automatic pulse(input logic d);
		@(posedge clk);
		iv <= 1'b0;
		dset <= d;
		wset <= !d;
		@(posedge clk);
		dset <= 1'b0;
		wset <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic bad);
		int n;
		n = 0;
		@(posedge clk);
		iv <= 1'b0;
		awa <= ad;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
		end while (bv !== 1'b1 && n < 50);
		br <= 1'b0;
		chk(34'(bresp), 34'(bad ? asi_pkg::RESP_SLVERR : asi_pkg::RESP_OKAY));
		if (bv !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask

	task automatic rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e,
		input logic bad);
		int n;
		n = 0;
		rq.push_back({bad ? asi_pkg::RESP_SLVERR : asi_pkg::RESP_OKAY, 24'h0, m, 24'h0, e});
		@(posedge clk);
		iv <= 1'b0;
		ara <= ad;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arr)
				arv <= 1'b0;
		end while (rv !== 1'b1 && n < 50);
		rr <= 1'b0;
		if (rv !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask

	always @(posedge clk) begin
		if (rv === 1'b1 && rr) begin
			re = rq.pop_front();
			chk({rresp, rdat & re[63:32]}, {re[65:64], re[31:0]});
		end
		if (rst_n && wb.pc_inc === 1'b1) begin
			if (wq.size() == 0)
				chk(34'h1, 34'h0);
			else begin
				chk(34'(ew(wb.acc_we, wb.acc, wb.b_we, wb.b, wb.skip)), 34'(wq.pop_front()));
				chk({32'h0, cs, ms}, {32'h0, sq.pop_front()});
			end
		end
	end

	initial begin
		{rst_n, iv, dset, wset, pd, awv, wv, br, arv, rr} = '0;
		{acc, bb, awa, ara, wd, insn, res} = '0;
		seed = 32'h8BD7EF5E;
		ce = 1'b1;
		cm = 1'b0;
		num_errors = 0;
		checks_done = 0;
		repeat (20)
			@(posedge clk);
		rst_n <= 1'b1;
		r = rnd();
		res <= r[9:0];
		a = r[13:10];
		b = r[17:14];
		rd(8'h00, 8'hFF, 8'h00, 1'b0);
		rd(8'h20, 8'hFF, 8'h00, 1'b1);
		wr(8'h08, 8'h01, 1'b1);
		ex(asi_pkg::OP_LOAD_AB_FROM_CONVERSION, a, b, ew(1, r[5:2], 1, r[9:6], 0));
		ex(asi_pkg::OP_LOAD_ACC_FROM_RESULT_LOW, a, b, ew(1, {r[1:0], 2'h0}, 0, 0, 0));
		ex(asi_pkg::OP_STORE_AB_TO_COMPARATOR, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h0C, 8'hFF, 8'h00, 1'b0);
		ex(asi_pkg::OP_STORE_ACC_TO_CONVERTER_CTRL, a | 4'h8, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_LOAD_ACC_FROM_CONVERTER_CTRL, a, b, ew(1, a | 4'h8, 0, 0, 0));
		ex(asi_pkg::OP_STORE_AB_TO_COMPARATOR, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_LOAD_AB_FROM_CONVERSION, 4'h0, 4'h0, ew(1, a, 1, b, 0));
		rd(8'h0C, 8'hFF, {b, a}, 1'b0);
		wr(8'h00, {b, 4'h0}, 1'b0);
		ex(asi_pkg::OP_LOAD_ACC_FROM_CLOCK_CTRL, a, b, ew(1, b, 0, 0, 0));
		ex(asi_pkg::OP_LOAD_AB_FROM_CONVERSION, a, b, ew(1, r[5:2], 1, r[9:6], 0));
		ex(asi_pkg::OP_STORE_ACC_TO_CLOCK_CTRL, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h00, 8'hF0, {a, 4'h0}, 1'b0);
		// With the clock enable low a presented word must leave no trace
		ce <= 1'b0;
		ex(asi_pkg::OP_STORE_ACC_TO_CLOCK_CTRL, ~a, b, '0);
		@(posedge clk);
		iv <= 1'b0;
		ce <= 1'b1;
		rd(8'h00, 8'hF0, {a, 4'h0}, 1'b0);
		pulse(1'b1);
		ex(asi_pkg::OP_SKIP_IF_CONVERSION_DONE, a, b, ew(0, 0, 0, 0, 1));
		ex(asi_pkg::OP_SKIP_IF_CONVERSION_DONE, a, b, ew(0, 0, 0, 0, 0));
		wr(8'h04, 8'h04, 1'b0);
		pulse(1'b1);
		ex(asi_pkg::OP_SKIP_IF_CONVERSION_DONE, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h01, 8'h01, 1'b0);
		ex(asi_pkg::OP_CONVERSION_START, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h01, 8'h00, 1'b0);
		ex(asi_pkg::OP_STORE_ACC_TO_CONVERTER_CTRL, 4'h8, b, ew(0, 0, 0, 0, 0));
		cm = 1'b1;
		ex(asi_pkg::OP_CONVERSION_START, a, b, ew(0, 0, 0, 0, 0));
		cm = 1'b0;
		ex(asi_pkg::OP_STORE_ACC_TO_CONVERTER_CTRL, 4'h0, b, ew(0, 0, 0, 0, 0));
		pd <= 1'b1;
		ex(asi_pkg::OP_SKIP_IF_POWERDOWN_FLAG, a, b, ew(0, 0, 0, 0, 1));
		ex(asi_pkg::OP_SKIP_IF_POWERDOWN_FLAG, a, b, ew(0, 0, 0, 0, 1));
		pulse(1'b0);
		pd <= 1'b0;
		ex(asi_pkg::OP_SKIP_IF_POWERDOWN_FLAG, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_WATCHDOG_RESTART, a, b, ew(0, 0, 0, 0, 1));
		ex(asi_pkg::OP_WATCHDOG_RESTART, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_WATCHDOG_DISABLE_ARM, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_NO_OPERATION, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_WATCHDOG_RESTART, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h10, 8'h00, 1'b0);
		ex(asi_pkg::OP_WATCHDOG_DISABLE_ARM, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_WATCHDOG_RESTART, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h10, 8'h10, 1'b0);
		ex(asi_pkg::OP_SELECT_CERAMIC_OSC, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h60, 8'h20, 1'b0);
		ex(asi_pkg::OP_SELECT_RC_OSC, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h60, 8'h40, 1'b0);
		ex(asi_pkg::OP_RAM_BACKUP_ENTER, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_POWERDOWN_ARM, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_NO_OPERATION, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_RAM_BACKUP_ENTER, a, b, ew(0, 0, 0, 0, 0));
		rd(8'h08, 8'h08, 8'h00, 1'b0);
		ex(asi_pkg::OP_POWERDOWN_ARM, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_RAM_BACKUP_ENTER, a, b, ew(0, 0, 0, 0, 0));
		ex(asi_pkg::OP_NO_OPERATION, a, b, '0);
		rd(8'h08, 8'h08, 8'h08, 1'b0);
		chk(34'(wq.size()), 34'h0);
		stop_test();
	end
endmodule // test_adc_and_system_instructions
`default_nettype wire
